// file: verilog/t16io_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - capture-capable instance lets ch0/ch1 capture; otherwise compare only
// - free-running mode: ch0/ch1 select bits pick capture or compare; ch2/ch3 compare only
// - pulse width mode capture on ch0/ch1; interval and one-shot modes compare only
// - channel registers writable while running, 16-bit wide, reset to zero
// - interval enable: FFFF to 0000, count, toggle ch0 output, load buffer
// - interval ch0 match clears counter, toggles ch0 output, raises ch0 irq
// - interval period is ch0 value plus one count clocks
// - interval ch1 buffered; match toggles ch1 output, irq, no clear
// - four channel irqs (match or capture) plus one overflow irq
// - one-shot enable waits for trigger, then FFFF to 0000, counts, pulses
// - after the pulse counter clears to zero, halts, awaits next trigger
// - trigger during an active one-shot pulse is ignored
// - delay is chb count clocks, width chb to ch0 inclusive
// - one-shot ch0 irq one count step after match; chb irq on match
// - delay channels are 1 to 3, each match raises its irq
// - only the software trigger bit starts a one-shot
// - channel with chb above ch0 produces no pulse
module t16io_timer #(
  parameter bit CAPTURE_CAPABLE = 1'b1,
  parameter int NUM_CH = 4,
  parameter int DIV_W = 7
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // capture pins
  input wire logic [1:0] i_capture_pin,
  // timer outputs and events
  output logic [NUM_CH-1:0] o_toggle_output,
  output logic [NUM_CH-1:0] o_oneshot_pulse_output,
  output t16io_pkg::t16io_irq_type o_irq
);
  // ahb and control state
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_pend_reg;
  logic [7:0] rd_addr_reg;
  logic counter_enable_bit_reg;
  logic [2:0] presc_reg;
  logic [2:0] mode_reg;
  logic ch0_capture_select_reg;
  logic ch1_capture_select_reg;
  logic [15:0] ccr_reg [NUM_CH];
  logic [15:0] buf_reg [NUM_CH];
  logic [15:0] count_reg;
  logic [NUM_CH-1:0] flag_reg;
  logic ovf_flag_reg;
  logic running_reg;
  logic os_ch0_hit_reg;
  logic trig_pulse;
  logic tick;
  logic [NUM_CH-1:0] cap_mode;
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] cap_evt;
  logic [1:0] cap_s1_reg;
  logic [1:0] cap_s2_reg;
  logic [1:0] cap_s3_reg;
  t16io_pkg::t16io_os_state_type os_state_reg;

  // channel index from a register offset, or NUM_CH when not a channel
  function automatic int ccr_index(input logic [7:0] a);
    int idx;
    idx = NUM_CH;
    for (int k = 0; k < NUM_CH; k++) begin
      if (a == t16io_pkg::OFF_CCR0 + 8'(4 * k)) begin
        idx = k;
      end
    end
    return idx;
  endfunction : ccr_index

  // address phase accepted
  logic addr_ok;
  assign addr_ok = i_hsel && i_hready && i_htrans[1];

  // ahb pipeline: zero wait state, always okay
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok && i_hwrite;
      rd_pend_reg <= addr_ok && !i_hwrite;
      wr_addr_reg <= {i_haddr[7:2], 2'b00};
      rd_addr_reg <= {i_haddr[7:2], 2'b00};
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // read data registered one cycle after the address phase
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_ok && !i_hwrite) begin
      o_hrdata <= 32'h0000_0000;
      case ({i_haddr[7:2], 2'b00})
        t16io_pkg::OFF_CTL0: o_hrdata[7:0] <= {counter_enable_bit_reg, 4'h0, presc_reg};
        t16io_pkg::OFF_CTL1: o_hrdata[7:0] <= {5'h00, mode_reg};
        t16io_pkg::OFF_OPT0: o_hrdata[7:0] <= {2'b00, ch1_capture_select_reg, ch0_capture_select_reg, 4'h0};
        t16io_pkg::OFF_CNT: o_hrdata[15:0] <= count_reg;
        t16io_pkg::OFF_FLAG: o_hrdata[4:0] <= {ovf_flag_reg, flag_reg};
        t16io_pkg::OFF_OUT: o_hrdata[7:0] <= {o_oneshot_pulse_output, o_toggle_output};
        default: begin
          if (ccr_index({i_haddr[7:2], 2'b00}) < NUM_CH) begin
            o_hrdata[15:0] <= ccr_reg[ccr_index({i_haddr[7:2], 2'b00})];
          end
        end
      endcase
    end
  end

  // control registers; trigger bit is a write-one pulse
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      counter_enable_bit_reg <= 1'b0;
      presc_reg <= 3'h0;
      mode_reg <= t16io_pkg::MODE_INTERVAL;
      ch0_capture_select_reg <= 1'b0;
      ch1_capture_select_reg <= 1'b0;
      trig_pulse <= 1'b0;
    end else begin
      trig_pulse <= 1'b0;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          t16io_pkg::OFF_CTL0: begin
            counter_enable_bit_reg <= i_hwdata[t16io_pkg::CTL0_ENABLE_POS];
            presc_reg <= i_hwdata[t16io_pkg::CTL0_PRESC_LSB +: t16io_pkg::CTL0_PRESC_W];
          end
          t16io_pkg::OFF_CTL1: begin
            mode_reg <= i_hwdata[t16io_pkg::CTL1_MODE_LSB +: t16io_pkg::CTL1_MODE_W];
            trig_pulse <= i_hwdata[t16io_pkg::CTL1_TRIG_POS];
          end
          t16io_pkg::OFF_OPT0: begin
            ch0_capture_select_reg <= i_hwdata[t16io_pkg::OPT0_CCS0_POS];
            ch1_capture_select_reg <= i_hwdata[t16io_pkg::OPT0_CCS1_POS];
          end
          default: ;
        endcase
      end
    end
  end

  // count clock enable
  t16io_prescaler #(.DIV_W(DIV_W)) u_presc (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_run(counter_enable_bit_reg),
    .i_sel(presc_reg),
    .o_tick(tick)
  );

  // capture pin synchroniser and rising edge detect
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cap_s1_reg <= 2'b00;
      cap_s2_reg <= 2'b00;
      cap_s3_reg <= 2'b00;
    end else begin
      cap_s1_reg <= i_capture_pin;
      cap_s2_reg <= cap_s1_reg;
      cap_s3_reg <= cap_s2_reg;
    end
  end

  // per-channel role and compare or capture event
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      if (g < 2) begin : g_cap
        assign cap_mode[g] = CAPTURE_CAPABLE && counter_enable_bit_reg &&
          ((mode_reg == t16io_pkg::MODE_PWIDTH) ||
           (mode_reg == t16io_pkg::MODE_FREERUN &&
            (g == 0 ? ch0_capture_select_reg : ch1_capture_select_reg)));
        assign cap_evt[g] = cap_mode[g] && cap_s2_reg[g] && !cap_s3_reg[g];
      end else begin : g_cmp
        assign cap_mode[g] = 1'b0;
        assign cap_evt[g] = 1'b0;
      end
      assign match[g] = running_reg && tick && !cap_mode[g] && (count_reg == buf_reg[g]);
    end
  endgenerate

  // channel registers: software write, or capture of the count
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < NUM_CH; k++) begin
        ccr_reg[k] <= t16io_pkg::CCR_RESET;
      end
    end else begin
      for (int k = 0; k < NUM_CH; k++) begin
        if (cap_evt[k]) begin
          ccr_reg[k] <= count_reg;
        end else if (wr_pend_reg && ccr_index(wr_addr_reg) == k) begin
          ccr_reg[k] <= i_hwdata[15:0];
        end
      end
    end
  end

  // one-shot trigger latch so a trigger between ticks is not lost; start wins over a late trigger
  logic trig_hold_reg;
  logic start_os;
  assign start_os = tick && counter_enable_bit_reg && mode_reg == t16io_pkg::MODE_ONESHOT &&
    os_state_reg == t16io_pkg::OS_WAIT && trig_hold_reg;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trig_hold_reg <= 1'b0;
    end else if (start_os || !counter_enable_bit_reg) begin
      trig_hold_reg <= 1'b0;
    end else if (trig_pulse && os_state_reg == t16io_pkg::OS_WAIT) begin
      trig_hold_reg <= 1'b1;
    end
  end

  // compare buffers reload at start and at each ch0 clear
  logic start_evt;
  logic reload;
  assign start_evt = (tick && !running_reg && counter_enable_bit_reg && mode_reg != t16io_pkg::MODE_ONESHOT) ||
    start_os;
  assign reload = start_evt || (match[0] && mode_reg == t16io_pkg::MODE_INTERVAL);
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < NUM_CH; k++) begin
        buf_reg[k] <= t16io_pkg::CCR_RESET;
      end
    end else if (reload) begin
      for (int k = 0; k < NUM_CH; k++) begin
        buf_reg[k] <= ccr_reg[k];
      end
    end
  end

  // counter and run state
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_reg <= t16io_pkg::CNT_IDLE;
      running_reg <= 1'b0;
      os_state_reg <= t16io_pkg::OS_WAIT;
      os_ch0_hit_reg <= 1'b0;
    end else if (!counter_enable_bit_reg) begin
      count_reg <= t16io_pkg::CNT_IDLE;
      running_reg <= 1'b0;
      os_state_reg <= t16io_pkg::OS_WAIT;
      os_ch0_hit_reg <= 1'b0;
    end else if (tick) begin
      if (mode_reg == t16io_pkg::MODE_ONESHOT) begin
        case (os_state_reg)
          t16io_pkg::OS_WAIT: begin
            if (trig_hold_reg) begin
              count_reg <= t16io_pkg::CNT_ZERO;
              running_reg <= 1'b1;
              os_state_reg <= t16io_pkg::OS_RUN;
            end
          end
          t16io_pkg::OS_RUN: begin
            count_reg <= count_reg + 16'h0001;
            if (match[0]) begin
              os_state_reg <= t16io_pkg::OS_END;
              os_ch0_hit_reg <= 1'b1;
            end
          end
          t16io_pkg::OS_END: begin
            count_reg <= t16io_pkg::CNT_ZERO;
            running_reg <= 1'b0;
            os_ch0_hit_reg <= 1'b0;
            os_state_reg <= t16io_pkg::OS_WAIT;
          end
          default: os_state_reg <= t16io_pkg::OS_WAIT;
        endcase
      end else if (!running_reg) begin
        count_reg <= t16io_pkg::CNT_ZERO;
        running_reg <= 1'b1;
      end else if (match[0] && mode_reg == t16io_pkg::MODE_INTERVAL) begin
        count_reg <= t16io_pkg::CNT_ZERO;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // interval toggle outputs
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_toggle_output <= '0;
    end else if (mode_reg == t16io_pkg::MODE_INTERVAL && counter_enable_bit_reg) begin
      if (start_evt || match[0]) begin
        o_toggle_output[0] <= ~o_toggle_output[0];
      end
      if (match[1]) begin
        o_toggle_output[1] <= ~o_toggle_output[1];
      end
    end
  end

  // one-shot pulse: active from chb match through ch0 match
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_oneshot_pulse_output <= '0;
    end else if (mode_reg != t16io_pkg::MODE_ONESHOT || !counter_enable_bit_reg) begin
      o_oneshot_pulse_output <= '0;
    end else begin
      for (int k = 1; k < NUM_CH; k++) begin
        if (match[k] && buf_reg[k] <= buf_reg[0]) begin
          o_oneshot_pulse_output[k] <= 1'b1;
        end else if (os_state_reg == t16io_pkg::OS_END && tick) begin
          o_oneshot_pulse_output[k] <= 1'b0;
        end
      end
    end
  end

  // event pulses and sticky flags; set wins over software clear
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= '0;
      flag_reg <= '0;
      ovf_flag_reg <= 1'b0;
    end else begin
      o_irq.cc[0] <= (mode_reg == t16io_pkg::MODE_ONESHOT) ?
        (tick && os_ch0_hit_reg) : (match[0] || cap_evt[0]);
      for (int k = 1; k < NUM_CH; k++) begin
        o_irq.cc[k] <= match[k] || cap_evt[k];
      end
      o_irq.ovf <= tick && running_reg && count_reg == t16io_pkg::CNT_IDLE &&
        mode_reg == t16io_pkg::MODE_FREERUN;
      for (int k = 0; k < NUM_CH; k++) begin
        if (o_irq.cc[k]) begin
          flag_reg[k] <= 1'b1;
        end else if (wr_pend_reg && wr_addr_reg == t16io_pkg::OFF_FLAG && i_hwdata[k]) begin
          flag_reg[k] <= 1'b0;
        end
      end
      if (o_irq.ovf) begin
        ovf_flag_reg <= 1'b1;
      end else if (wr_pend_reg && wr_addr_reg == t16io_pkg::OFF_FLAG && i_hwdata[NUM_CH]) begin
        ovf_flag_reg <= 1'b0;
      end
    end
  end
endmodule : t16io_timer
`default_nettype wire

// file: inc/t16io_pkg.sv
package t16io_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTL0 = 8'h00;
  localparam logic [7:0] OFF_CTL1 = 8'h04;
  localparam logic [7:0] OFF_OPT0 = 8'h08;
  localparam logic [7:0] OFF_CCR0 = 8'h10;
  localparam logic [7:0] OFF_CCR1 = 8'h14;
  localparam logic [7:0] OFF_CCR2 = 8'h18;
  localparam logic [7:0] OFF_CCR3 = 8'h1c;
  localparam logic [7:0] OFF_CNT = 8'h20;
  localparam logic [7:0] OFF_FLAG = 8'h24;
  localparam logic [7:0] OFF_OUT = 8'h28;
  // field positions
  localparam int CTL0_ENABLE_POS = 7;
  localparam int CTL0_PRESC_LSB = 0;
  localparam int CTL0_PRESC_W = 3;
  localparam int CTL1_TRIG_POS = 6;
  localparam int CTL1_MODE_LSB = 0;
  localparam int CTL1_MODE_W = 3;
  localparam int OPT0_CCS0_POS = 4;
  localparam int OPT0_CCS1_POS = 5;
  // reset values
  localparam logic [15:0] CCR_RESET = 16'h0000;
  localparam logic [15:0] CNT_IDLE = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  // mode encodings
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_ONESHOT = 3'h3;
  localparam logic [2:0] MODE_FREERUN = 3'h5;
  localparam logic [2:0] MODE_PWIDTH = 3'h6;
  // one-shot sequencer states
  typedef enum logic [1:0] {OS_WAIT, OS_RUN, OS_END} t16io_os_state_type;
  // event bundle: four channel events plus overflow
  typedef struct packed {
    logic ovf;
    logic [3:0] cc;
  } t16io_irq_type;
endpackage : t16io_pkg

// file: verilog/t16io_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// count clock enable: one pulse every 2**sel system clocks
module t16io_prescaler #(
  parameter int DIV_W = 7
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // control
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  // enable pulse
  output logic o_tick
);
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] mask;

  // low bits of divider that must all be one
  always_comb begin
    mask = DIV_W'((1 << i_sel) - 1);
  end

  // free divider, cleared while stopped
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_reg <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      div_reg <= '0;
      o_tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 1'b1;
      o_tick <= ((div_reg & mask) == mask);
    end
  end
endmodule : t16io_prescaler
`default_nettype wire

// file: test/t16io_checker.sv
`timescale 1ns/1ps
`default_nettype none
// port watcher for the timer; the mode field is shadowed from bus writes
module t16io_checker #(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // pins and events
  input wire logic [1:0] i_capture_pin,
  input wire logic [NUM_CH-1:0] o_toggle_output,
  input wire logic [NUM_CH-1:0] o_oneshot_pulse_output,
  input wire t16io_pkg::t16io_irq_type o_irq
);
  logic ctl1_wr_reg;
  logic [2:0] mode_reg;
  wire in_interval = (mode_reg == t16io_pkg::MODE_INTERVAL);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // note a write address phase aimed at the control register holding the mode
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctl1_wr_reg <= 1'b0;
    end else begin
      ctl1_wr_reg <= i_hsel && i_hready && i_htrans[1] && i_hwrite && (i_haddr[7:0] == t16io_pkg::OFF_CTL1);
    end
  end
  // the mode field lands with the data phase
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_reg <= t16io_pkg::MODE_INTERVAL;
    end else if (ctl1_wr_reg) begin
      mode_reg <= i_hwdata[2:0];
    end
  end
  // toggle seen in this or the previous cycle
  sequence s_moved0;
    $changed(o_toggle_output[0]) or ($past(o_toggle_output[0]) != $past(o_toggle_output[0], 2));
  endsequence
  sequence s_moved1;
    $changed(o_toggle_output[1]) or ($past(o_toggle_output[1]) != $past(o_toggle_output[1], 2));
  endsequence
  sequence s_pulse_end;
    $fell(o_oneshot_pulse_output[1]);
  endsequence
  property p_ready; o_hreadyout; endproperty
  property p_okay; !o_hresp; endproperty
  property p_ovf; (mode_reg != t16io_pkg::MODE_FREERUN) |-> !o_irq.ovf; endproperty
  property p_quiet; in_interval |-> (o_oneshot_pulse_output == {NUM_CH{1'b0}}); endproperty
  property p_cc0_toggle; (in_interval && o_irq.cc[0]) |-> s_moved0; endproperty
  property p_cc1_toggle; (in_interval && o_irq.cc[1]) |-> s_moved1; endproperty
  property p_pulse_end; s_pulse_end |-> ##[0:1] o_irq.cc[0]; endproperty
  property p_pulse_start;
    $rose(o_oneshot_pulse_output[1]) |-> ##[0:1] ($past(o_irq.cc[1]) || o_irq.cc[1]);
  endproperty
  a_ready: assert property (p_ready) else $error("bus not zero-wait");
  a_okay: assert property (p_okay) else $error("bus response not okay");
  a_ovf: assert property (p_ovf) else $error("overflow event outside free-run");
  a_quiet: assert property (p_quiet) else $error("pulse output in interval mode");
  a_cc0_toggle: assert property (p_cc0_toggle) else $error("ch0 event without toggle");
  a_cc1_toggle: assert property (p_cc1_toggle) else $error("ch1 event without toggle");
  a_pulse_end: assert property (p_pulse_end) else $error("pulse end without ch0 event");
  a_pulse_start: assert property (p_pulse_start) else $error("pulse start without ch1 event");
endmodule : t16io_checker

bind t16io_timer t16io_checker #(.NUM_CH(NUM_CH)) u_t16io_checker (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
  .i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_capture_pin(i_capture_pin), .o_toggle_output(o_toggle_output),
  .o_oneshot_pulse_output(o_oneshot_pulse_output), .o_irq(o_irq)
);
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s); end end
module tb_top;
  // bus and pin stimulus
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans, cap;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] tog, pls, ptog, ppls;
  t16io_pkg::t16io_irq_type irq;
  wire hready = hreadyout;
  // bench bookkeeping
  logic [35:0] q[$];
  logic rd_ph;
  int fails, cmp_count, cyc, t0, t1, r1, n1, n3;
  int seed = 32'hff0d43ec;
  string kname[5] = '{"read data", "ch0 toggle period", "ch1 toggle period", "pulse width", "ch2 pulse offset"};
  t16io_timer u_t16io_timer (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_capture_pin(cap), .o_toggle_output(tog),
    .o_oneshot_pulse_output(pls), .o_irq(irq)
  );
  // 20 mhz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // verdict and end of run
  task automatic results;
    if (fails == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask : bus
  task automatic expect_ev(input logic [3:0] k, input logic [31:0] v);
    q.push_back({k, v});
  endtask : expect_ev
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expect_ev(4'h0, e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  // match a result with the oldest note of its kind
  task automatic note(input logic [3:0] k, input logic [31:0] v);
    int idx[$];
    idx = q.find_first_index(x) with (x[35:32] == k);
    if (idx.size() > 0) begin
      `CHK(kname[k], q[idx[0]][31:0], v)
      q.delete(idx[0]);
    end
  endtask : note
  // output watcher: read data, toggle periods, pulse widths; noise on capture pins
  always @(posedge clk) begin
    cyc++;
    cap <= 2'($random(seed));
    if (rd_ph) note(4'h0, hrdata);
    if (tog[0] !== ptog[0]) begin
      note(4'h1, cyc - t0);
      t0 = cyc;
    end
    if (tog[1] !== ptog[1]) begin
      note(4'h2, cyc - t1);
      t1 = cyc;
    end
    if (pls[1] === 1'b1 && ppls[1] === 1'b0) begin
      r1 = cyc;
      n1++;
    end
    if (pls[1] === 1'b0 && ppls[1] === 1'b1) note(4'h3, cyc - r1);
    if (pls[2] === 1'b1 && ppls[2] === 1'b0) note(4'h4, cyc - r1);
    if (pls[3] === 1'b1 && ppls[3] === 1'b0) n3++;
    ptog = tog;
    ppls = pls;
    rd_ph = hsel && htrans[1] && !hwrite;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  // main sequence
  initial begin
    int p, c0, b1, b2, d0;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    cap = 2'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(t16io_pkg::OFF_CCR0, 32'h0);
    rd(t16io_pkg::OFF_CCR1, 32'h0);
    rd(8'h30, 32'h0);
    rd(t16io_pkg::OFF_CNT, 32'hffff);
    // interval mode, ch1 equal to ch0 for a square wave
    for (int k = 0; k < 2; k++) begin
      p = {$random(seed)} % 3;
      c0 = 3 + {$random(seed)} % 28;
      wr(t16io_pkg::OFF_CTL1, {29'h0, t16io_pkg::MODE_INTERVAL});
      wr(t16io_pkg::OFF_CCR0, {16'hffff, 16'(c0)});
      wr(t16io_pkg::OFF_CCR1, 32'(c0));
      wr(t16io_pkg::OFF_CTL0, 32'h80 | 32'(p));
      rd(t16io_pkg::OFF_CCR0, 32'(c0));
      repeat (3 * ((c0 + 1) << p)) @(posedge clk);
      repeat (2) expect_ev(4'h1, (c0 + 1) << p);
      repeat (2) expect_ev(4'h2, (c0 + 1) << p);
      repeat (3 * ((c0 + 1) << p)) @(posedge clk);
      `CHK("pending notes", 0, q.size())
      wr(t16io_pkg::OFF_CTL0, 32'h0);
      @(posedge clk);
      rd(t16io_pkg::OFF_CNT, 32'hffff);
    end
    // ch1 parked at ffff stays still while ch0 keeps running
    b1 = tog[1];
    wr(t16io_pkg::OFF_CCR1, 32'hffff);
    wr(t16io_pkg::OFF_CTL0, 32'h80);
    repeat (100) @(posedge clk);
    `CHK("parked ch1 toggle", b1, tog[1])
    wr(t16io_pkg::OFF_CTL0, 32'h0);
    // one-shot pulses on ch1 and ch2, ch3 beyond ch0 stays silent
    b1 = 2 + {$random(seed)} % 9;
    b2 = b1 + {$random(seed)} % 6;
    d0 = b2 + 3 + {$random(seed)} % 18;
    wr(t16io_pkg::OFF_CTL1, {29'h0, t16io_pkg::MODE_ONESHOT});
    wr(t16io_pkg::OFF_CCR0, 32'(d0));
    wr(t16io_pkg::OFF_CCR1, 32'(b1));
    wr(t16io_pkg::OFF_CCR2, 32'(b2));
    wr(t16io_pkg::OFF_CCR3, 32'(d0 + 1));
    wr(t16io_pkg::OFF_CTL0, 32'h80);
    n1 = 0;
    n3 = 0;
    for (int k = 0; k < 2; k++) begin
      expect_ev(4'h3, d0 - b1 + 1);
      expect_ev(4'h4, b2 - b1);
      wr(t16io_pkg::OFF_CTL1, 32'h43);
      while (pls[1] !== 1'b1) @(posedge clk);
      wr(t16io_pkg::OFF_CTL1, 32'h43);
      repeat (d0 + 4) @(posedge clk);
      rd(t16io_pkg::OFF_CNT, 32'h0);
    end
    @(posedge clk);
    `CHK("ch1 pulse count", n1, 2)
    `CHK("ch3 pulse count", n3, 0)
    `CHK("pending notes", 0, q.size())
    // pulse width mode: ch0 and ch1 capture noise edges, ch2 and ch3 still compare
    wr(t16io_pkg::OFF_CTL0, 32'h0);
    wr(t16io_pkg::OFF_FLAG, 32'h1f);
    rd(t16io_pkg::OFF_FLAG, 32'h0);
    wr(t16io_pkg::OFF_CTL1, {29'h0, t16io_pkg::MODE_PWIDTH});
    wr(t16io_pkg::OFF_CTL0, 32'h80);
    repeat (60) @(posedge clk);
    rd(t16io_pkg::OFF_FLAG, 32'h0f);
    results();
  end
endmodule : tb_top
`default_nettype wire
